// ### rtl/pfm_pkg.sv
// package: constants and types of the predictive failure monitor
// ------------------------------------------------------------------
// Operation
// - disable bit suspends all monitoring and reporting
// - on-line data gathered alongside normal operations
// - on-line-only select skips off-line measurement
// - rezero measures now, saves, restarts hour timer
// - time to next measurement is readable
// - hourly measurement waits for an idle loop
// - off-line measurement abandoned on host activity
// - on-line processing delay stays below 75 ms
// - report method one sends sense code, fault type
// - raised failure code survives bus reset, power cycle
// - per attribute interval counter counts operations
// - per attribute failure counter counts interval errors
// - errors above threshold make interval unacceptable
// - every decision clears both counters, restarts interval
// - history counter up on bad, down on good
// - history reaching threshold signals predictive failure
// - each attribute has its own history counter
// ------------------------------------------------------------------
package pfm_pkg;

    // ------------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------------
    localparam int N_ATTR  = 4;
    localparam int CNT_W   = 16;
    localparam int HIST_W  = 8;
    localparam int TIMER_W = 40;
    localparam int MEAS_W  = 16;

    localparam longint CLK_HZ           = 100_000_000;
    localparam longint HOUR_S           = 3600;
    localparam logic [TIMER_W-1:0] HOUR_CYCLES =
        TIMER_W'(HOUR_S * CLK_HZ);
    localparam longint MAX_DELAY_MS     = 75;
    localparam longint MAX_DELAY_CYCLES = MAX_DELAY_MS * (CLK_HZ / 1000);
    localparam logic [MEAS_W-1:0] MEAS_CYCLES = 16'h0010;

    // ------------------------------------------------------------------
    // per attribute limits
    // ------------------------------------------------------------------
    localparam logic [N_ATTR-1:0][CNT_W-1:0] INTERVAL_LEN =
        {16'h0400, 16'h0200, 16'h0100, 16'h0080};
    localparam logic [N_ATTR-1:0][CNT_W-1:0] ERR_THRESH =
        {16'h0020, 16'h0010, 16'h0008, 16'h0004};
    localparam logic [N_ATTR-1:0][HIST_W-1:0] PRED_THRESH =
        {8'h10, 8'h0C, 8'h08, 8'h04};

    // ------------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL     = 8'h00;
    localparam logic [7:0] ADR_STATUS   = 8'h04;
    localparam logic [7:0] ADR_TIMER_LO = 8'h08;
    localparam logic [7:0] ADR_TIMER_HI = 8'h0C;
    localparam logic [7:0] ADR_HIST     = 8'h10;
    localparam logic [7:0] ADR_SENSE    = 8'h14;

    localparam int CTRL_DISABLE_BIT = 0;
    localparam int CTRL_ONLINE_BIT  = 1;
    localparam int CTRL_METHOD_LSB  = 4;
    localparam int METHOD_W         = 4;
    localparam int STAT_IDLE_BIT    = 8;
    localparam int STAT_MEAS_BIT    = 9;

    localparam logic [METHOD_W-1:0] METHOD_RESET = 4'h0;
    localparam logic [METHOD_W-1:0] METHOD_SENSE = 4'h1;
    localparam logic [23:0]         SENSE_CODE   = 24'h015D00;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {PH_WAIT, PH_PEND, PH_MEAS} phase_t;

    typedef struct packed {
        logic                             wb_ack;
        logic [31:0]                      wb_dat;
        logic                             monitor_disable;
        logic                             online_only_select;
        logic [METHOD_W-1:0]              report_method;
        logic                             sync1;
        logic                             sync2;
        logic                             sync3;
        logic                             idle;
        logic [N_ATTR-1:0][CNT_W-1:0]     ic;
        logic [N_ATTR-1:0][CNT_W-1:0]     fc;
        logic [N_ATTR-1:0][HIST_W-1:0]    hist;
        logic [N_ATTR-1:0]                pred;
        logic                             report_valid;
        logic [23:0]                      report_sense;
        logic [7:0]                       fault_type_field;
        phase_t                           phase;
        logic [TIMER_W-1:0]               timer;
        logic [MEAS_W-1:0]                meas_cnt;
        logic                             meas_busy;
        logic                             meas_save;
    } state_t;

endpackage

// ### rtl/predictive_failure_monitor.sv
// module: per attribute error rate monitor with wishbone registers
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module predictive_failure_monitor #(
    parameter logic [pfm_pkg::TIMER_W-1:0] HOUR_CYCLES =
        pfm_pkg::HOUR_CYCLES
) (
    input  wire logic                        core_clk,
    input  wire logic                        reset,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic [31:0]                      wb_dat_o,
    output logic                             wb_ack_o,
    input  wire logic [pfm_pkg::N_ATTR-1:0]  op_valid,
    input  wire logic [pfm_pkg::N_ATTR-1:0]  op_error,
    input  wire logic                        loop_reset,
    input  wire logic                        loop_idle,
    input  wire logic                        rezero_command,
    input  wire logic                        nv_restore_valid,
    input  wire logic [pfm_pkg::N_ATTR-1:0]  nv_restore_code,
    output logic [pfm_pkg::N_ATTR-1:0]       nv_code,
    output logic                             report_valid,
    output logic [23:0]                      report_sense,
    output logic [7:0]                       fault_type_field,
    output logic                             meas_active,
    output logic                             meas_save
);

    pfm_pkg::state_t s;
    pfm_pkg::state_t n;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0]                   rd;
        logic                          active;
        logic                          any_new;
        logic                          bad;
        logic                          good;
        logic [pfm_pkg::CNT_W-1:0]     ic_n;
        logic [pfm_pkg::CNT_W-1:0]     fc_n;
        logic [pfm_pkg::HIST_W-1:0]    hist_n;
        logic [pfm_pkg::N_ATTR-1:0]    clr;
        logic [7:0]                    ftype;
        rd      = 32'h0000_0000;
        active  = 1'b0;
        any_new = 1'b0;
        bad     = 1'b0;
        good    = 1'b0;
        ic_n    = '0;
        fc_n    = '0;
        hist_n  = '0;
        clr     = '0;
        ftype   = 8'h00;
        n       = s;

        n.wb_ack       = 1'b0;
        n.report_valid = 1'b0;
        n.meas_save    = 1'b0;

        // loop idle pin: three flops, level taken when last two agree
        n.sync1 = loop_idle;
        n.sync2 = s.sync1;
        n.sync3 = s.sync2;
        if (s.sync2 == s.sync3) begin
            n.idle = s.sync3;
        end

        // register read mux
        case (wb_adr_i)
            pfm_pkg::ADR_CTRL: begin
                rd[pfm_pkg::CTRL_DISABLE_BIT] = s.monitor_disable;
                rd[pfm_pkg::CTRL_ONLINE_BIT]  = s.online_only_select;
                rd[pfm_pkg::CTRL_METHOD_LSB +: pfm_pkg::METHOD_W] =
                    s.report_method;
            end
            pfm_pkg::ADR_STATUS: begin
                rd[pfm_pkg::N_ATTR-1:0]      = s.pred;
                rd[pfm_pkg::STAT_IDLE_BIT]   = s.idle;
                rd[pfm_pkg::STAT_MEAS_BIT]   = s.meas_busy;
            end
            pfm_pkg::ADR_TIMER_LO: begin
                rd = s.timer[31:0];
            end
            pfm_pkg::ADR_TIMER_HI: begin
                rd[pfm_pkg::TIMER_W-33:0] = s.timer[pfm_pkg::TIMER_W-1:32];
            end
            pfm_pkg::ADR_HIST: begin
                rd = s.hist;
            end
            pfm_pkg::ADR_SENSE: begin
                rd = {s.fault_type_field, s.report_sense};
            end
            default: begin
                rd = 32'h0000_0000;
            end
        endcase

        // wishbone classic slave, one wait state
        if (wb_cyc_i && wb_stb_i && !s.wb_ack) begin
            n.wb_ack = 1'b1;
            n.wb_dat = rd;
        end
        // writes land at the edge that samples ack high
        if (wb_cyc_i && wb_stb_i) begin
            if (wb_we_i && s.wb_ack) begin
                case (wb_adr_i)
                    pfm_pkg::ADR_CTRL: begin
                        if (wb_sel_i[0]) begin
                            n.monitor_disable =
                                wb_dat_i[pfm_pkg::CTRL_DISABLE_BIT];
                            n.online_only_select =
                                wb_dat_i[pfm_pkg::CTRL_ONLINE_BIT];
                            n.report_method = wb_dat_i[
                                pfm_pkg::CTRL_METHOD_LSB +:
                                pfm_pkg::METHOD_W];
                        end
                    end
                    pfm_pkg::ADR_STATUS: begin
                        if (wb_sel_i[0]) begin
                            clr = wb_dat_i[pfm_pkg::N_ATTR-1:0];
                        end
                    end
                    default: begin
                        clr = '0;
                    end
                endcase
            end
        end
        n.pred = n.pred & ~clr;

        // stored code reloaded from non-volatile copy
        if (nv_restore_valid) begin
            n.pred = nv_restore_code;
        end

        active = !s.monitor_disable;

        // per attribute rate monitor, one cycle per operation
        for (int i = 0; i < pfm_pkg::N_ATTR; i++) begin
            if (active && op_valid[i]) begin
                ic_n = s.ic[i] + 16'h0001;
                fc_n = s.fc[i] + {15'h0000, op_error[i]};
                bad  = fc_n > pfm_pkg::ERR_THRESH[i];
                good = !bad && ic_n >= pfm_pkg::INTERVAL_LEN[i];
                hist_n = s.hist[i];
                if (bad) begin
                    if (s.hist[i] != 8'hFF) begin
                        hist_n = s.hist[i] + 8'h01;
                    end
                end else if (good && s.hist[i] != 8'h00) begin
                    hist_n = s.hist[i] - 8'h01;
                end
                if (bad || good) begin
                    n.ic[i] = '0;
                    n.fc[i] = '0;
                end else begin
                    n.ic[i] = ic_n;
                    n.fc[i] = fc_n;
                end
                n.hist[i] = hist_n;
                if (hist_n >= pfm_pkg::PRED_THRESH[i] && !s.pred[i]) begin
                    n.pred[i] = 1'b1;
                    any_new   = 1'b1;
                end
            end
            if (loop_reset) begin
                n.ic[i] = '0;
                n.fc[i] = '0;
            end
        end

        // lowest newly failing attribute names the fault type
        for (int i = pfm_pkg::N_ATTR - 1; i >= 0; i--) begin
            if (n.pred[i] && !s.pred[i]) begin
                ftype = 8'(i + 1);
            end
        end
        if (active && any_new &&
            s.report_method == pfm_pkg::METHOD_SENSE) begin
            n.report_valid     = 1'b1;
            n.report_sense     = pfm_pkg::SENSE_CODE;
            n.fault_type_field = ftype;
        end

        // off-line measurement scheduler
        if (!active) begin
            n.phase = s.phase;
        end else if (rezero_command) begin
            if (s.online_only_select) begin
                n.timer = HOUR_CYCLES;
                n.phase = pfm_pkg::PH_WAIT;
            end else begin
                n.phase    = pfm_pkg::PH_MEAS;
                n.meas_cnt = '0;
            end
        end else begin
            case (s.phase)
                pfm_pkg::PH_WAIT: begin
                    if (s.timer != '0) begin
                        n.timer = s.timer - 40'h00_0000_0001;
                    end else if (s.online_only_select) begin
                        n.timer = HOUR_CYCLES;
                    end else begin
                        n.phase = pfm_pkg::PH_PEND;
                    end
                end
                pfm_pkg::PH_PEND: begin
                    if (s.online_only_select) begin
                        n.timer = HOUR_CYCLES;
                        n.phase = pfm_pkg::PH_WAIT;
                    end else if (s.idle) begin
                        n.phase    = pfm_pkg::PH_MEAS;
                        n.meas_cnt = '0;
                    end
                end
                pfm_pkg::PH_MEAS: begin
                    if (!s.idle || s.online_only_select) begin
                        n.phase = pfm_pkg::PH_PEND;
                    end else if (s.meas_cnt ==
                                 pfm_pkg::MEAS_CYCLES - 16'h0001) begin
                        n.meas_save = 1'b1;
                        n.timer     = HOUR_CYCLES;
                        n.phase     = pfm_pkg::PH_WAIT;
                    end else begin
                        n.meas_cnt = s.meas_cnt + 16'h0001;
                    end
                end
                default: begin
                    n.phase = pfm_pkg::PH_WAIT;
                end
            endcase
        end
        n.meas_busy = n.phase == pfm_pkg::PH_MEAS;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s                    <= '0;
            s.monitor_disable    <= 1'b0;
            s.online_only_select <= 1'b0;
            s.report_method      <= pfm_pkg::METHOD_RESET;
            s.phase              <= pfm_pkg::PH_WAIT;
            s.timer              <= HOUR_CYCLES;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign wb_dat_o         = s.wb_dat;
    assign wb_ack_o         = s.wb_ack;
    assign nv_code          = s.pred;
    assign report_valid     = s.report_valid;
    assign report_sense     = s.report_sense;
    assign fault_type_field = s.fault_type_field;
    assign meas_active      = s.meas_busy;
    assign meas_save        = s.meas_save;

endmodule

// ### verification/pfm_chk.sv
// checker: port properties of the failure monitor
`timescale 1ns/1ps
module pfm_chk #(
    parameter logic [pfm_pkg::TIMER_W-1:0] HOUR_CYCLES =
        pfm_pkg::HOUR_CYCLES
) (
    input wire logic                       core_clk,
    input wire logic                       reset,
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_we_i,
    input wire logic [7:0]                 wb_adr_i,
    input wire logic [3:0]                 wb_sel_i,
    input wire logic [31:0]                wb_dat_i,
    input wire logic                       wb_ack_o,
    input wire logic [pfm_pkg::N_ATTR-1:0] nv_restore_code,
    input wire logic                       nv_restore_valid,
    input wire logic [pfm_pkg::N_ATTR-1:0] nv_code,
    input wire logic                       loop_idle,
    input wire logic                       rezero_command,
    input wire logic                       report_valid,
    input wire logic [23:0]                report_sense,
    input wire logic [7:0]                 fault_type_field,
    input wire logic                       meas_active,
    input wire logic                       meas_save
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [7:0] ctrl;
    // ------------------------------------------------------------------
    // shadow of the control register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl <= 8'h00;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == pfm_pkg::ADR_CTRL) begin
            ctrl <= wb_dat_i[7:0];
        end
    end
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack missing");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    rezero_start_a: assert property (
        rezero_command && ctrl[1:0] == 2'h0 && loop_idle
        && $past(loop_idle, 5) |=> meas_active) else $error("no start");
    meas_save_a: assert property (
        meas_save |-> !meas_active && $past(meas_active)
        && $past(meas_active, 16)) else $error("save timing");
    online_skip_a: assert property (
        ctrl[1] && $past(ctrl[1]) |-> !$rose(meas_active))
        else $error("off-line run in on-line mode");
    disable_quiet_a: assert property (
        ctrl[0] && $past(ctrl[0]) |-> !report_valid && !$rose(meas_active))
        else $error("activity while disabled");
    report_form_a: assert property (
        report_valid |-> report_sense == 24'h015D00
        && $past(ctrl[7:4]) == 4'h1
        && fault_type_field inside {[8'h01:8'h04]}) else $error("bad report");
    report_code_a: assert property (report_valid |-> |nv_code)
        else $error("report without code");
    code_keep_a: assert property (
        !$past(nv_restore_valid) && !$past(wb_ack_o && wb_we_i)
        |-> (nv_code & $past(nv_code)) == $past(nv_code))
        else $error("stored code lost");
    report_c: cover property (report_valid);
    save_c: cover property (meas_save);
    rezero_c: cover property (rezero_command ##1 meas_active);
endmodule
bind predictive_failure_monitor pfm_chk #(.HOUR_CYCLES(HOUR_CYCLES)) chk (
    .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .nv_restore_code(nv_restore_code), .nv_restore_valid(nv_restore_valid),
    .nv_code(nv_code), .loop_idle(loop_idle),
    .rezero_command(rezero_command), .report_valid(report_valid),
    .report_sense(report_sense), .fault_type_field(fault_type_field),
    .meas_active(meas_active), .meas_save(meas_save));

// ### verification/host_loop_model.sv
// model: host side of the loop, drives idle level and rezero
`timescale 1ns/1ps
module host_loop_model (
    input  wire logic core_clk,
    input  wire logic busy_req,
    input  wire logic rz_req,
    output logic      loop_idle,
    output logic      rezero_command
);
    initial loop_idle = 1'h0;
    initial rezero_command = 1'h0;
    // idle follows host traffic; rezero pulses every other cycle while a request is held
    always @(posedge core_clk) begin
        loop_idle <= !busy_req;
        rezero_command <= rz_req && !rezero_command;
    end
endmodule

// ### verification/predictive_failure_monitor_tb.sv
// testbench: self-checking scenarios for the failure monitor
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
    check_count++; \
    if ((s) !== (e)) begin \
        mismatches++; \
        $display("ERROR %s exp %0h got %0h", n, e, s); \
    end \
end
module predictive_failure_monitor_tb;
    logic        core_clk = 1'h0, reset = 1'h1, loop_reset = 1'h0;
    logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [7:0]  wb_adr_i = 8'h00, fault_type_field;
    logic [3:0]  wb_sel_i = 4'h0, nv_restore_code = 4'h0, nv_code;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic        wb_ack_o, loop_idle, rezero_command, nv_restore_valid = 1'h0;
    logic        busy_req = 1'h1, rz_req = 1'h0, report_valid;
    logic        meas_active, meas_save;
    logic [3:0]  op_valid = 4'h0, op_error = 4'h0;
    logic [23:0] report_sense;
    int          mismatches = 0, check_count = 0, n_rep = 0, n_save = 0, t;
    predictive_failure_monitor #(.HOUR_CYCLES(40'h00000000C8)) uut (
        .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .op_valid(op_valid), .op_error(op_error),
        .loop_reset(loop_reset), .loop_idle(loop_idle),
        .rezero_command(rezero_command), .nv_restore_valid(nv_restore_valid),
        .nv_restore_code(nv_restore_code), .nv_code(nv_code),
        .report_valid(report_valid), .report_sense(report_sense),
        .fault_type_field(fault_type_field), .meas_active(meas_active),
        .meas_save(meas_save));
    host_loop_model host (.core_clk(core_clk), .busy_req(busy_req),
        .rz_req(rz_req), .loop_idle(loop_idle),
        .rezero_command(rezero_command));
    always @(posedge core_clk) begin
        if (report_valid === 1'h1) n_rep++;
        if (meas_save === 1'h1) n_save++;
    end
    task automatic wb(input logic [7:0] a, input logic we,
                      input logic [31:0] d);
        int w;
        w = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do begin
            @(posedge core_clk);
            w++;
        end while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        `CHK("ack wait", 2, w)
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'h0, 32'h0);
        `CHK("read", e, q)
    endtask
    task automatic op(input int a, input logic e, input int n);
        repeat (n) begin
            op_valid[a] <= 1'h1;
            op_error[a] <= e;
            @(posedge core_clk);
        end
        op_valid <= 4'h0;
        op_error <= 4'h0;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic t_fail;
        rd(pfm_pkg::ADR_CTRL, 32'h0);
        wb(8'hFC, 1'h1, 32'h1);
        rd(8'hFC, 32'h0);
        wb(pfm_pkg::ADR_CTRL, 1'h1, 32'h10);
        for (int i = 0; i < 4; i++) begin
            `CHK("early report", 0, n_rep)
            op(0, 1'h1, 5);
        end
        `CHK("report", 1, n_rep)
        rd(pfm_pkg::ADR_HIST, 32'h4);
        `CHK("sense", 24'h015D00, report_sense)
        `CHK("fault", 8'h01, fault_type_field)
        rd(pfm_pkg::ADR_STATUS, 32'h1);
        wb(pfm_pkg::ADR_STATUS, 1'h1, 32'h1);
        rd(pfm_pkg::ADR_STATUS, 32'h0);
    endtask
    task automatic t_rate;
        op(0, 1'h1, 4);
        op(0, 1'h0, 124);
        op(0, 1'h1, 4);
        op(0, 1'h0, 1);
        op(1, 1'h1, 8);
        op(1, 1'h0, 248);
        rd(pfm_pkg::ADR_HIST, 32'h3);
        wb(pfm_pkg::ADR_CTRL, 1'h1, 32'h11);
        op(0, 1'h1, 5);
        wb(pfm_pkg::ADR_CTRL, 1'h1, 32'h10);
        rd(pfm_pkg::ADR_HIST, 32'h3);
        loop_reset <= 1'h1;
        cyc(1);
        loop_reset <= 1'h0;
        op(0, 1'h1, 1);
        rd(pfm_pkg::ADR_HIST, 32'h3);
        `CHK("code", 4'h1, nv_code)
    endtask
    task automatic t_meas;
        // reload the hour timer so only rezero can start a measurement
        wb(pfm_pkg::ADR_CTRL, 1'h1, 32'h12);
        wb(pfm_pkg::ADR_CTRL, 1'h1, 32'h10);
        busy_req <= 1'h0;
        cyc(8);
        rz_req <= 1'h1;
        cyc(1);
        rz_req <= 1'h0;
        t = n_save;
        cyc(3);
        `CHK("run", 1'h1, meas_active)
        cyc(30);
        `CHK("saved", 1'h1, n_save > t)
        wb(pfm_pkg::ADR_TIMER_LO, 1'h0, 32'h0);
        `CHK("timer", 1'h1, q <= 32'hC8 && q > 32'hB0)
        rd(pfm_pkg::ADR_TIMER_HI, 32'h0);
        rz_req <= 1'h1;
        cyc(1);
        rz_req <= 1'h0;
        t = n_save;
        cyc(4);
        busy_req <= 1'h1;
        cyc(8);
        `CHK("abandon", 1'h0, meas_active)
        cyc(30);
        `CHK("no save", t, n_save)
        wb(pfm_pkg::ADR_CTRL, 1'h1, 32'h12);
        busy_req <= 1'h0;
        cyc(8);
        rz_req <= 1'h1;
        cyc(1);
        rz_req <= 1'h0;
        cyc(4);
        `CHK("online", 1'h0, meas_active)
        busy_req <= 1'h1;
        nv_restore_valid <= 1'h1;
        nv_restore_code <= 4'h8;
        cyc(1);
        nv_restore_valid <= 1'h0;
        cyc(2);
        `CHK("restore", 4'h8, nv_code)
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        mismatches++;
        end_sim;
    end
    initial begin
        cyc(8);
        reset <= 1'h0;
        cyc(1);
        t_fail;
        t_rate;
        t_meas;
        end_sim;
    end
endmodule
